// ===== hw/pedm_pkg.sv
/*
  Shared constants and types of the PHY power-down and mode control block.
  Assumes a 125 MHz system clock and a 32-bit classic Wishbone register bus.
*/
package pedm_pkg;

  // ----------------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned ENERGY_DETECT_SLEEP_XOVER_MS = 2976;
  localparam int unsigned MAN_XOVER_SAMPLES = 32;
  localparam int unsigned MAN_XOVER_SAMPLE_MS = 62;
  localparam int unsigned MAN_XOVER_MS = MAN_XOVER_SAMPLES * MAN_XOVER_SAMPLE_MS;
  localparam int unsigned ENERGY_LOSS_MS = 256;
  localparam int unsigned ENERGY_LOSS_AN_MS = 1500;
  localparam int unsigned ENERGY_LOSS_TICKS = ENERGY_LOSS_MS / TICK_MS;
  localparam int unsigned ENERGY_LOSS_AN_TICKS = ENERGY_LOSS_AN_MS / TICK_MS;

  // ----------------------------------------------------------------------
  // Register indexes, byte address is four times the index
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_CFG = 8'h10;
  localparam logic [7:0] IDX_MODE = 8'h11;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h20;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h21;
  localparam logic [7:0] IDX_CTRL = 8'h22;

  // ----------------------------------------------------------------------
  // Field positions, write masks and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned CFG_EEE_BIT = 2;
  localparam int unsigned CFG_ENERGY_DETECT_SLEEP_XOVER_BIT = 1;
  localparam int unsigned CFG_MAN_XOVER_BIT = 0;
  localparam int unsigned MODE_ENERGY_DETECT_SLEEP_BIT = 13;
  localparam int unsigned MODE_ALTERNATE_IRQ_SELECT_BIT = 6;
  localparam int unsigned MODE_ENERGY_BIT = 1;
  localparam int unsigned CTRL_ANEG_BIT = 0;
  localparam int unsigned CTRL_SRST_BIT = 1;
  localparam int unsigned CTRL_PHYRST_BIT = 2;
  localparam logic [15:0] CFG_WMASK = 16'h0007;
  localparam logic [15:0] MODE_WMASK = 16'h2040;
  localparam logic [15:0] CFG_RST = 16'h0001;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic ENERGY_RST = 1'h1;

  // ----------------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------------
  localparam int unsigned IRQ_WIDTH = 2;
  localparam int unsigned IRQ_ENERGY_UP = 0;
  localparam int unsigned IRQ_ENERGY_DOWN = 1;

  localparam int unsigned XOVER_W = 13;
  localparam int unsigned TIMER_W = 11;

  typedef enum logic [0:0] {
    EN_ABSENT = 1'b0,
    EN_PRESENT = 1'b1
  } pedm_energy_e;

  typedef struct packed {
    logic low_power_ethernet_enable;
    logic energy_detect_sleep_enable;
    logic alternate_irq_select;
    logic line_energy_present;
    logic aneg_enable;
    logic [XOVER_W-1:0] crossover_extra_ms;
  } pedm_phy_ctrl_s;

endpackage

// ===== hw/pedm_ctrl.sv
/*
  PHY energy-detect power-down and crossover-extension control with its
  management registers on a classic Wishbone slave port.
  Assumes one 125 MHz clock, an asynchronous active-low reset, a raw energy
  detector level arriving from the analog front end on another timing, and a
  static auto-negotiation strap pin.
*/
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/10ps

// Overview of operation
// - Configuration bit 2 turns low-power Ethernet on when set and off when clear, reset 0.
// - With energy-detect sleep enabled and configuration bit 1 set the crossover time grows by 2976 ms.
// - With negotiation off and configuration bit 0 set the crossover time grows by 32 samples of 62 ms, reset 1.
// - The manual crossover-extension bit has no effect while negotiation is enabled.
// - A PHY reset from the device reset control clears the soft-reset fields only while the soft reset bit is set.
// - Mode bit 13 enables energy-detect sleep when 1, reset 0.
// - Mode bit 6 selects the alternate interrupt scheme when 1, reset 0.
// - Read-only mode bit 1 shows line energy and drops after 256 ms without energy, 1500 ms with negotiation.
// - Hardware reset sets the energy bit, and a soft reset does too when negotiation is or will be enabled.
module pedm_ctrl
  import pedm_pkg::*;
#(
  parameter int unsigned TICK_COUNT = TICK_CYCLES
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic line_energy_raw,
  input wire logic aneg_strap,
  output pedm_phy_ctrl_s phy_ctrl,
  output logic irq
);

  // ----------------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [9:0] adr, input logic [7:0] idx);
    hit = (adr[9:2] == idx);
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] sel,
                                          input logic [15:0] wmask);
    logic [15:0] nv;
    nv = old;
    if (sel[0]) begin
      nv[7:0] = wd[7:0];
    end
    if (sel[1]) begin
      nv[15:8] = wd[15:8];
    end
    merge16 = (nv & wmask) | (old & ~wmask);
  endfunction

  // ----------------------------------------------------------------------
  // Bus request
  // ----------------------------------------------------------------------
  logic req;
  logic wr;
  logic wr_cfg;
  logic wr_mode;
  logic wr_stat;
  logic wr_mask;
  logic wr_ctrl;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i;
  assign wr_cfg = wr && hit(wb_adr_i, IDX_CFG);
  assign wr_mode = wr && hit(wb_adr_i, IDX_MODE);
  assign wr_stat = wr && hit(wb_adr_i, IDX_IRQ_STAT) && wb_sel_i[0];
  assign wr_mask = wr && hit(wb_adr_i, IDX_IRQ_MASK) && wb_sel_i[0];
  assign wr_ctrl = wr && hit(wb_adr_i, IDX_CTRL) && wb_sel_i[0];

  // ----------------------------------------------------------------------
  // Strap capture and device reset control
  // ----------------------------------------------------------------------
  logic strap_taken;
  logic aneg_strap_q;
  logic [2:0] strap_sync;
  logic [1:0] strap_fill;
  logic [1:0] ctrl;
  logic phy_reset_pulse;
  logic soft_reset_cleared_field_clear;
  logic aneg_en;

  assign aneg_en = ctrl[CTRL_ANEG_BIT];
  assign phy_reset_pulse = wr_ctrl && wb_dat_i[CTRL_PHYRST_BIT];
  assign soft_reset_cleared_field_clear = phy_reset_pulse && ctrl[CTRL_SRST_BIT];

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      strap_sync <= 3'h0;
      strap_fill <= 2'h0;
    end else begin
      strap_sync <= {strap_sync[1:0], aneg_strap};
      if (strap_fill != 2'h3) begin
        strap_fill <= strap_fill + 2'h1;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      strap_taken <= 1'b0;
      aneg_strap_q <= 1'b0;
    end else if (!strap_taken && strap_fill == 2'h3 && strap_sync[1] == strap_sync[2]) begin
      strap_taken <= 1'b1;
      aneg_strap_q <= strap_sync[2];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl <= CTRL_RST;
    end else if (!strap_taken) begin
      ctrl[CTRL_ANEG_BIT] <= strap_sync[2];
    end else if (wr_ctrl) begin
      ctrl <= wb_dat_i[1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Configuration and mode registers
  // ----------------------------------------------------------------------
  logic [15:0] cfg;
  logic [15:0] mode;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cfg <= CFG_RST;
    end else if (soft_reset_cleared_field_clear) begin
      cfg <= CFG_RST;
    end else if (wr_cfg) begin
      cfg <= merge16(cfg, wb_dat_i, wb_sel_i, CFG_WMASK);
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mode <= MODE_RST;
    end else if (soft_reset_cleared_field_clear) begin
      mode <= MODE_RST;
    end else if (wr_mode) begin
      mode <= merge16(mode, wb_dat_i, wb_sel_i, MODE_WMASK);
    end
  end

  // ----------------------------------------------------------------------
  // Line energy input synchroniser
  // ----------------------------------------------------------------------
  logic [2:0] energy_sync;
  logic energy_seen;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      energy_sync <= 3'h0;
    end else begin
      energy_sync <= {energy_sync[1:0], line_energy_raw};
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      energy_seen <= 1'b0;
    end else if (energy_sync[1] == energy_sync[2]) begin
      energy_seen <= energy_sync[2];
    end
  end

  // ----------------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------------
  logic [16:0] tick_cnt;
  logic tick;

  assign tick = (tick_cnt == 17'(TICK_COUNT - 1));

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tick_cnt <= 17'h0;
    end else if (tick) begin
      tick_cnt <= 17'h0;
    end else begin
      tick_cnt <= tick_cnt + 17'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Energy presence tracking
  // ----------------------------------------------------------------------
  pedm_energy_e energy_state;
  pedm_energy_e next_energy_state;
  logic [TIMER_W-1:0] quiet_ms;
  logic [TIMER_W-1:0] quiet_limit;
  logic soft_energy_set;

  assign quiet_limit = aneg_en ? TIMER_W'(ENERGY_LOSS_AN_TICKS) : TIMER_W'(ENERGY_LOSS_TICKS);
  assign soft_energy_set = phy_reset_pulse && (aneg_en || aneg_strap_q);

  always_comb begin
    next_energy_state = energy_state;
    case (energy_state)
      EN_ABSENT: begin
        if (energy_seen || soft_energy_set) begin
          next_energy_state = EN_PRESENT;
        end
      end
      EN_PRESENT: begin
        if (soft_energy_set) begin
          next_energy_state = EN_PRESENT;
        end else if (!energy_seen && tick && quiet_ms >= quiet_limit - TIMER_W'(1)) begin
          next_energy_state = EN_ABSENT;
        end
      end
      default: begin
        next_energy_state = EN_PRESENT;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      energy_state <= EN_PRESENT;
    end else begin
      energy_state <= next_energy_state;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      quiet_ms <= '0;
    end else if (energy_seen || soft_energy_set || energy_state == EN_ABSENT) begin
      quiet_ms <= '0;
    end else if (tick) begin
      quiet_ms <= quiet_ms + TIMER_W'(1);
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------------
  logic [IRQ_WIDTH-1:0] irq_stat;
  logic [IRQ_WIDTH-1:0] irq_mask;
  logic [IRQ_WIDTH-1:0] irq_event;

  assign irq_event[IRQ_ENERGY_UP] = (energy_state == EN_ABSENT) && (next_energy_state == EN_PRESENT);
  assign irq_event[IRQ_ENERGY_DOWN] = (energy_state == EN_PRESENT) && (next_energy_state == EN_ABSENT);

  genvar gi;
  generate
    for (gi = 0; gi < IRQ_WIDTH; gi++) begin : g_irq
      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          irq_stat[gi] <= 1'b0;
        end else if (irq_event[gi]) begin
          irq_stat[gi] <= 1'b1;
        end else if (wr_stat && wb_dat_i[gi]) begin
          irq_stat[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irq_mask <= '0;
    end else if (wr_mask) begin
      irq_mask <= wb_dat_i[IRQ_WIDTH-1:0];
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // ----------------------------------------------------------------------
  // Outputs toward the PHY core
  // ----------------------------------------------------------------------
  logic [XOVER_W-1:0] next_xover;

  always_comb begin
    next_xover = '0;
    if (mode[MODE_ENERGY_DETECT_SLEEP_BIT] && cfg[CFG_ENERGY_DETECT_SLEEP_XOVER_BIT]) begin
      next_xover = XOVER_W'(ENERGY_DETECT_SLEEP_XOVER_MS);
    end
    if (!aneg_en && cfg[CFG_MAN_XOVER_BIT]) begin
      next_xover = next_xover + XOVER_W'(MAN_XOVER_MS);
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      phy_ctrl <= '0;
    end else begin
      phy_ctrl.low_power_ethernet_enable <= cfg[CFG_EEE_BIT];
      phy_ctrl.energy_detect_sleep_enable <= mode[MODE_ENERGY_DETECT_SLEEP_BIT];
      phy_ctrl.alternate_irq_select <= mode[MODE_ALTERNATE_IRQ_SELECT_BIT];
      phy_ctrl.line_energy_present <= (energy_state == EN_PRESENT);
      phy_ctrl.aneg_enable <= aneg_en;
      phy_ctrl.crossover_extra_ms <= next_xover;
    end
  end

  // ----------------------------------------------------------------------
  // Read data and acknowledge
  // ----------------------------------------------------------------------
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0;
    if (hit(wb_adr_i, IDX_CFG)) begin
      next_rdata[15:0] = cfg & CFG_WMASK;
    end else if (hit(wb_adr_i, IDX_MODE)) begin
      next_rdata[15:0] = mode & MODE_WMASK;
      next_rdata[MODE_ENERGY_BIT] = (energy_state == EN_PRESENT);
    end else if (hit(wb_adr_i, IDX_IRQ_STAT)) begin
      next_rdata[IRQ_WIDTH-1:0] = irq_stat;
    end else if (hit(wb_adr_i, IDX_IRQ_MASK)) begin
      next_rdata[IRQ_WIDTH-1:0] = irq_mask;
    end else if (hit(wb_adr_i, IDX_CTRL)) begin
      next_rdata[1:0] = ctrl;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wb_dat_o <= 32'h0;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= next_rdata;
    end
  end

endmodule

// ===== bench/pedm_ctrl_checker.sv
/*
  Port-level checks of the PHY power-down and mode control block.
  Assumes it is bound into pedm_ctrl and sees only that module's ports.
*/
`timescale 1ns/10ps
module pedm_ctrl_checker
  import pedm_pkg::*;
#(
  parameter int unsigned TICK_COUNT = TICK_CYCLES
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic line_energy_raw,
  input wire pedm_phy_ctrl_s phy_ctrl,
  input wire logic irq
);
  // ----------------------------------------------------------------------
  // Cycles since the line last carried energy.
  // ----------------------------------------------------------------------
  localparam int unsigned EARLY = 255 * TICK_COUNT;
  localparam int unsigned LATE = 1502 * TICK_COUNT + 8;
  logic [31:0] quiet_cnt;
  logic prev_present;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prev_present <= 1'b0;
    end else begin
      prev_present <= phy_ctrl.line_energy_present;
    end
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      quiet_cnt <= '0;
    end else if (line_energy_raw || (phy_ctrl.line_energy_present && !prev_present)) begin
      quiet_cnt <= '0;
    end else if (quiet_cnt < LATE) begin
      quiet_cnt <= quiet_cnt + 32'h1;
    end
  end
  // ----------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held longer than one cycle");
  property p_ack_resp;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("request not answered next cycle");
  property p_upper_zero;
    wb_ack_o |-> wb_dat_o[31:16] == 16'h0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read half not zero");
  property p_cfg_res;
    wb_ack_o && !wb_we_i && wb_adr_i[9:2] == IDX_CFG |-> (wb_dat_o[15:0] & 16'hfff8) == 16'h0000;
  endproperty
  a_cfg_res: assert property (p_cfg_res) else $error("config reserved bits set");
  property p_mode_res;
    wb_ack_o && !wb_we_i && wb_adr_i[9:2] == IDX_MODE |-> (wb_dat_o[15:0] & 16'hdfbd) == 16'h0000;
  endproperty
  a_mode_res: assert property (p_mode_res) else $error("mode reserved bits set");
  property p_xover_energy_detect_sleep;
    !phy_ctrl.energy_detect_sleep_enable |-> phy_ctrl.crossover_extra_ms inside {13'h0000, 13'h07c0};
  endproperty
  a_xover_energy_detect_sleep: assert property (p_xover_energy_detect_sleep) else $error("sleep extension without sleep");
  property p_xover_aneg;
    phy_ctrl.aneg_enable |-> phy_ctrl.crossover_extra_ms inside {13'h0000, 13'h0ba0};
  endproperty
  a_xover_aneg: assert property (p_xover_aneg) else $error("manual extension with negotiation");
  property p_loss_early;
    $fell(phy_ctrl.line_energy_present) |-> quiet_cnt >= EARLY;
  endproperty
  a_loss_early: assert property (p_loss_early) else $error("energy dropped too early");
  property p_loss_late;
    quiet_cnt == LATE |-> !phy_ctrl.line_energy_present;
  endproperty
  a_loss_late: assert property (p_loss_late) else $error("energy kept too long");
  c_read: cover property (wb_ack_o && !wb_we_i);
  c_loss: cover property ($fell(phy_ctrl.line_energy_present));
  c_irq: cover property ($rose(irq));
  c_xover_full: cover property (phy_ctrl.crossover_extra_ms == 13'h1360);
endmodule

bind pedm_ctrl pedm_ctrl_checker #(.TICK_COUNT(TICK_COUNT)) u_chk (.clock(clock), .nrst(nrst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .line_energy_raw(line_energy_raw), .phy_ctrl(phy_ctrl), .irq(irq));

// ===== bench/pedm_link_partner.sv
/*
  Link partner model: puts energy on the line while asked to.
  Assumes the block samples the line asynchronously.
*/
`timescale 1ns/10ps
module pedm_link_partner (
  input wire logic clock,
  input wire logic send_energy,
  output logic line_energy_raw
);
  // Energy changes on the falling edge, out of phase with the block.
  always @(negedge clock) begin
    line_energy_raw <= send_energy;
  end
endmodule

// ===== bench/pedm_ctrl_tb_top.sv
/*
  Self-checking bench of the PHY power-down and mode control block.
  Assumes the block, its package, the checker and the partner model.
*/
`timescale 1ns/10ps
module pedm_ctrl_tb_top
  import pedm_pkg::*;
;
  localparam int unsigned TK = 10;
  typedef struct packed {
    logic [9:0] adr;
    logic [15:0] wd;
    logic [15:0] exp;
  } pedm_row_s;
  pedm_row_s rows [8];
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic cyc, stb, we, ack, send_energy, aneg_strap, irq, raw;
  logic [9:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_i, dat_o, rd;
  pedm_phy_ctrl_s phy_ctrl;
  int fail_count = 0;
  int check_count = 0;
  always #4 clock = ~clock;
  pedm_ctrl #(.TICK_COUNT(TK)) dut (.clock(clock), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .line_energy_raw(raw), .aneg_strap(aneg_strap), .phy_ctrl(phy_ctrl), .irq(irq));
  pedm_link_partner partner (.clock(clock), .send_energy(send_energy), .line_energy_raw(raw));
  // ----------------------------------------------------------------------
  // Tasks.
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (fail_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wb_xfer(input logic w, input logic [9:0] a, input logic [15:0] d);
    int n = 0;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h3;
    dat_i <= {16'h0000, d};
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = dat_o;
    if (n >= 50) begin
      fail_count++;
      report_and_stop();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    wb_xfer(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [9:0] a, input logic [15:0] exp);
    wb_xfer(1'b0, a, 16'h0000);
    chk(rd, {16'h0000, exp});
  endtask
  task automatic settle();
    repeat (2) @(posedge clock);
  endtask
  task automatic wait_loss(input int lo, input int hi);
    int n = 0;
    while (phy_ctrl.line_energy_present !== 1'b0 && n < 20000) begin
      @(posedge clock);
      n++;
    end
    chk(32'(n >= lo && n <= hi), 32'h1);
  endtask
  // ----------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------
  initial begin
    repeat (60000) @(posedge clock);
    fail_count++;
    report_and_stop();
  end
  initial begin
    {cyc, stb, we, adr, sel, dat_i} = '0;
    send_energy = 1'b1;
    aneg_strap = 1'b0;
    rows = '{'{10'h040, 16'hffff, 16'h0007}, '{10'h040, 16'h0000, 16'h0000}, '{10'h044, 16'hffff, 16'h2042},
      '{10'h044, 16'h0000, 16'h0002}, '{10'h084, 16'hffff, 16'h0003}, '{10'h088, 16'hffff, 16'h0003},
      '{10'h088, 16'h0000, 16'h0000}, '{10'h3fc, 16'hffff, 16'h0000}};
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    settle();
    rdchk(10'h040, 16'h0001);
    rdchk(10'h044, 16'h0002);
    chk(32'(phy_ctrl.crossover_extra_ms), 32'h07c0);
    for (int i = 0; i < 8; i++) begin
      wr(rows[i].adr, rows[i].wd);
      rdchk(rows[i].adr, rows[i].exp);
    end
    wr(10'h040, 16'h0003);
    wr(10'h044, 16'h2000);
    settle();
    chk(32'(phy_ctrl.crossover_extra_ms), 32'h1360);
    chk(32'(phy_ctrl.energy_detect_sleep_enable), 32'h1);
    wr(10'h040, 16'h0001);
    settle();
    chk(32'(phy_ctrl.crossover_extra_ms), 32'h07c0);
    wr(10'h088, 16'h0001);
    settle();
    chk(32'(phy_ctrl.crossover_extra_ms), 32'h0000);
    wr(10'h044, 16'h0040);
    wr(10'h040, 16'h0004);
    settle();
    chk(32'(phy_ctrl.alternate_irq_select), 32'h1);
    chk(32'(phy_ctrl.low_power_ethernet_enable), 32'h1);
    wr(10'h040, 16'h0006);
    wr(10'h088, 16'h0004);
    rdchk(10'h040, 16'h0006);
    wr(10'h088, 16'h0002);
    wr(10'h088, 16'h0006);
    rdchk(10'h040, 16'h0001);
    rdchk(10'h044, 16'h0002);
    wr(10'h040, 16'h0001);
    wr(10'h084, 16'h0003);
    wr(10'h080, 16'h0003);
    send_energy <= 1'b0;
    wait_loss(255 * TK, 258 * TK + 8);
    settle();
    chk(32'(irq), 32'h1);
    rdchk(10'h080, 16'h0002);
    wr(10'h084, 16'h0001);
    settle();
    chk(32'(irq), 32'h0);
    wr(10'h084, 16'h0003);
    wr(10'h080, 16'h0002);
    settle();
    chk(32'(irq), 32'h0);
    send_energy <= 1'b1;
    repeat (12) @(posedge clock);
    chk(32'(phy_ctrl.line_energy_present), 32'h1);
    rdchk(10'h080, 16'h0001);
    wr(10'h088, 16'h0001);
    send_energy <= 1'b0;
    wait_loss(1499 * TK, 1502 * TK + 8);
    nrst <= 1'b0;
    aneg_strap <= 1'b1;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    settle();
    rdchk(10'h044, 16'h0002);
    settle();
    chk(32'(phy_ctrl.aneg_enable), 32'h1);
    wait_loss(1499 * TK, 1502 * TK + 8);
    wr(10'h088, 16'h0005);
    rdchk(10'h044, 16'h0002);
    report_and_stop();
  end
endmodule
